// [sensor_rx_fifo_pointers.sv]
// Per-channel receive FIFO pointers and data memory for the sensor interface.
// Receivers write whole entries; the host reads words through each channel's
// FIFO read port or directly by address. Answers pass a two-entry buffer.
// Assumes one clock, a synchronous active-high reset, and a host that only
// raises a request while req_ready is high.
//
// Pointer model: both pointers count 32-bit words, so an entry is two words.
// The write pointer therefore steps by two per stored entry, and the read
// pointer steps by one per FIFO port read. Bit zero of the read pointer tells
// which half of the entry the next FIFO read returns. Both pointers wrap
// naturally at the width of the pointer, which is twice the entry depth.
//
// Hazard avoided: each channel's pointers are computed in their own slice of
// the next-state copy and read only that channel's own events. A write
// landing on a neighbour channel in the cycle after a read therefore cannot
// overwrite or stall the reading channel's pointer update.
//
// Limitation: the block does not guard against overrun. A receiver that
// writes more entries than the host has drained silently overwrites the
// oldest unread entries; software must watch the pointers to notice.
//
// Trade-off: a flush in the same cycle as a write wins and drops the entry,
// so the pointers and the memory can never disagree after a flush.
`timescale 1ns/1ps
module sensor_rx_fifo_pointers
    import rx_fifo_pkg::*;
#(
    parameter int unsigned CHANNELS = NUM_CHANNELS,
    parameter int unsigned PW       = PTR_WIDTH
) (
    // Clock and reset.
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    // Receiver write side, one entry per channel per cycle.
    input  wire logic [CHANNELS-1:0]       rx_wr_valid,
    input  wire rx_entry_s [CHANNELS-1:0]  rx_wr_entry,
    // Flush control, one pulse per channel.
    input  wire logic [CHANNELS-1:0]       fifo_flush_bit,
    // Host FIFO read port requests.
    input  wire logic                      fifo_rd_req,
    input  wire logic [$clog2(CHANNELS)-1:0] fifo_rd_chan,
    // Host direct memory read requests.
    input  wire logic                      mem_rd_req,
    input  wire logic [$clog2(CHANNELS)-1:0] mem_rd_chan,
    input  wire logic [PW-1:0]             mem_rd_index,
    input  wire logic                      mem_rd_high,
    output logic                           req_ready,
    // Read answer stream.
    output read_word_s                     rd_out,
    input  wire logic                      rd_out_ready,
    // Pointer observation.
    output logic [CHANNELS*PW-1:0]         fifo_read_pointer,
    output logic [CHANNELS*PW-1:0]         fifo_write_pointer
);

    localparam int unsigned CW    = $clog2(CHANNELS);
    localparam int unsigned DEPTH = 1 << (PW - 1);

    ////////////////////////////////////////////////////////////////////////////
    // State. The read pointer counts words, so one entry advances it by two.

    typedef struct packed {
        logic [CHANNELS-1:0][PW-1:0] rptr;
        logic [CHANNELS-1:0][PW-1:0] wptr;
        read_word_s [1:0]            buf_q;
        logic [1:0]                  buf_cnt;
    } state_s;

    state_s                    st;
    state_s                    next_st;
    rx_entry_s                 mem [CHANNELS][DEPTH];
    read_word_s                word_in;
    logic                      take;
    logic                      pop;

    function automatic logic [WORD_WIDTH-1:0] pick(input rx_entry_s e, input logic hi);
        pick = hi ? e.high : e.low;
    endfunction : pick

    // The buffer refuses only when full; a stalled drain thus stops requests.
    assign take = (fifo_rd_req || mem_rd_req) && (st.buf_cnt != 2'h2);
    assign pop  = st.buf_cnt != 2'h0 && rd_out_ready;

    always_comb begin
        logic [PW-1:0] rp;
        rp = st.rptr[fifo_rd_chan];
        word_in = '0;
        word_in.valid = 1'b1;
        if (fifo_rd_req) begin
            word_in.chan = fifo_rd_chan;
            word_in.half = rp[0];
            word_in.data = pick(mem[fifo_rd_chan][rp[PW-1:1]], rp[0]);
        end else begin
            word_in.chan = mem_rd_chan;
            word_in.half = mem_rd_high;
            word_in.data = pick(mem[mem_rd_chan][mem_rd_index[PW-2:0]], mem_rd_high);
        end
    end

    always_comb begin
        next_st = st;
        for (int c = 0; c < CHANNELS; c++) begin
            // Each channel's pointers see only their own events, so a write on a
            // neighbour can never collide with this channel's read update.
            if (fifo_flush_bit[c]) begin
                next_st.rptr[c] = PTR_RESET;
                next_st.wptr[c] = PTR_RESET;
            end else begin
                if (rx_wr_valid[c])
                    next_st.wptr[c] = st.wptr[c] + (PTR_STEP << 1);
                if (take && fifo_rd_req && fifo_rd_chan == CW'(c))
                    next_st.rptr[c] = st.rptr[c] + PTR_STEP;
            end
        end
        if (pop) begin
            next_st.buf_q[0] = st.buf_q[1];
            next_st.buf_cnt  = st.buf_cnt - 2'h1;
        end
        if (take) begin
            next_st.buf_q[pop ? st.buf_cnt - 2'h1 : st.buf_cnt] = word_in;
            next_st.buf_cnt = (pop ? st.buf_cnt - 2'h1 : st.buf_cnt) + 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge sys_clk) begin
        for (int c = 0; c < CHANNELS; c++) begin
            if (rx_wr_valid[c] && !fifo_flush_bit[c])
                mem[c][st.wptr[c][PW-1:1]] <= rx_wr_entry[c];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs come straight from state flip-flops.

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            req_ready <= 1'b0;
            rd_out    <= '0;
        end else begin
            req_ready <= next_st.buf_cnt != 2'h2;
            rd_out    <= next_st.buf_cnt != 2'h0 ? next_st.buf_q[0] : '0;
        end
    end

    // rd_out mirrors buffer head registered; pop uses st so head is consistent.
    assign fifo_read_pointer  = st.rptr;
    assign fifo_write_pointer = st.wptr;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_pair_adds_two: assert property (@(posedge sys_clk) disable iff (rst)
        (take && fifo_rd_req && fifo_rd_chan == 1'b0 && !fifo_flush_bit[0]) ##1
        (take && fifo_rd_req && fifo_rd_chan == 1'b0 && !fifo_flush_bit[0])
        |=> st.rptr[0] == $past(st.rptr[0], 2) + 4'h2)
        else $error("read pointer did not advance by two");

    a_pair_adds_two_b: assert property (@(posedge sys_clk) disable iff (rst)
        (take && fifo_rd_req && fifo_rd_chan == 1'b1 && !fifo_flush_bit[1]) ##1
        (take && fifo_rd_req && fifo_rd_chan == 1'b1 && !fifo_flush_bit[1])
        |=> st.rptr[1] == $past(st.rptr[1], 2) + 4'h2)
        else $error("read pointer did not advance by two");

    a_other_chan_one: assert property (@(posedge sys_clk) disable iff (rst)
        (!fifo_flush_bit[1] && !(take && fifo_rd_req && fifo_rd_chan == 1'b1))
        |=> $stable(st.rptr[1]))
        else $error("read pointer moved without own read");

    a_flush_clears_zero: assert property (@(posedge sys_clk) disable iff (rst)
        fifo_flush_bit[0] |=> st.rptr[0] == PTR_RESET && st.wptr[0] == PTR_RESET)
        else $error("flush did not clear pointers");

    // A stalled answer must not change under the host's feet.
    a_answer_holds: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_out.valid && !rd_out_ready) |=> $stable(rd_out))
        else $error("answer changed while stalled");

    a_other_chan_read: assert property (@(posedge sys_clk) disable iff (rst)
        (!fifo_flush_bit[0] && !(take && fifo_rd_req && fifo_rd_chan == 1'b0))
        |=> $stable(st.rptr[0]))
        else $error("read pointer moved without own read");

    a_flush_clears_ptrs: assert property (@(posedge sys_clk) disable iff (rst)
        fifo_flush_bit[1] |=> st.rptr[1] == PTR_RESET && st.wptr[1] == PTR_RESET)
        else $error("flush did not clear pointers");

    a_write_advances: assert property (@(posedge sys_clk) disable iff (rst)
        (rx_wr_valid[0] && !fifo_flush_bit[0]) |=> st.wptr[0] == $past(st.wptr[0]) + 4'h2)
        else $error("write pointer did not advance");

    a_direct_no_ptr: assert property (@(posedge sys_clk) disable iff (rst)
        (mem_rd_req && !fifo_rd_req && fifo_flush_bit == '0) |=> $stable(st.rptr))
        else $error("direct read moved a pointer");

endmodule : sensor_rx_fifo_pointers

// [rx_fifo_pkg.sv]
// Constants and carrier types for the per-channel receive FIFO pointer block.
// Assumes a single 40 MHz clock and a synchronous active-high reset.
// How it works
// - With two or more channels each channel has its own read pointer, moved only by reads of its own FIFO read port and by its own flush bit.
// - Two consecutive reads of a channel's FIFO read port fetch one entry and advance its read pointer by exactly 2.
// - A write on another channel in the cycle after a read never disturbs the reading channel's pointer update.
// - Direct memory reads through the low and high read registers return stored data without using the pointers.
// - Setting the flush bit of a channel resets that channel's write pointer and read pointer.
package rx_fifo_pkg;

    localparam int unsigned NUM_CHANNELS  = 2;
    localparam int unsigned PTR_WIDTH     = 4;
    localparam int unsigned WORD_WIDTH    = 32;
    localparam int unsigned WORDS_PER_ENT = 2;
    localparam logic [PTR_WIDTH-1:0] PTR_RESET = 4'h0;
    localparam logic [PTR_WIDTH-1:0] PTR_STEP  = 4'h1;

    typedef struct packed {
        logic [WORD_WIDTH-1:0] low;
        logic [WORD_WIDTH-1:0] high;
    } rx_entry_s;

    typedef struct packed {
        logic                       valid;
        logic [$clog2(NUM_CHANNELS)-1:0] chan;
        logic                       half;
        logic [WORD_WIDTH-1:0]      data;
    } read_word_s;

endpackage : rx_fifo_pkg

// [rx_model.sv]
// Receiver model: writes one entry on each channel whose go bit is high.
// Assumes the bench drives go just after a falling edge.
`timescale 1ns/1ps
module rx_model
    import rx_fifo_pkg::*;
(
    // Clock.
    input  wire logic                    sys_clk,
    // Write side.
    input  wire logic [NUM_CHANNELS-1:0] go,
    output logic [NUM_CHANNELS-1:0]      rx_wr_valid,
    output rx_entry_s [NUM_CHANNELS-1:0] rx_wr_entry
);
    logic [31:0] d = 32'h0000_0011;
    // Data moves every cycle, so an idle bus never repeats the last word.
    always_ff @(posedge sys_clk) d <= {d[30:0], d[31] ^ d[21] ^ d[1] ^ d[0]};
    assign rx_wr_valid = go;
    assign rx_wr_entry = {{d, ~d}, {d ^ 32'h5A5A_5A5A, d + 32'h1}};
endmodule : rx_model

// [test_sensor_rx_fifo_pointers.sv]
// Self-checking bench for the receive FIFO pointer block.
// Assumes rx_model on the write side; the bench plays the host.
`timescale 1ns/1ps
module test_sensor_rx_fifo_pointers;
    import rx_fifo_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, fifo_rd_req = 1'b0, mem_rd_req = 1'b0;
    logic mem_rd_high = 1'b0, rd_out_ready = 1'b1, req_ready;
    logic [0:0] fifo_rd_chan = 1'b0, mem_rd_chan = 1'b0;
    logic [3:0] mem_rd_index = 4'h0, rp [2] = '{4'h0, 4'h0};
    logic [2:0] wc [2] = '{3'h0, 3'h0};
    logic [1:0] go = 2'h0, flush = 2'h0, rx_wr_valid;
    logic [7:0] rptr, wptr;
    logic [31:0] rs = 32'd17;
    rx_entry_s [1:0] rx_wr_entry;
    rx_entry_s mem [2][8];
    read_word_s rd_out, q[$];
    int n_fail = 0, total_checks = 0, cyc = 0;
    rx_model i_rx (.sys_clk(sys_clk), .go(go), .rx_wr_valid(rx_wr_valid),
        .rx_wr_entry(rx_wr_entry));
    sensor_rx_fifo_pointers i_dut (.sys_clk(sys_clk), .rst(rst), .rx_wr_valid(rx_wr_valid),
        .rx_wr_entry(rx_wr_entry), .fifo_flush_bit(flush), .fifo_rd_req(fifo_rd_req),
        .fifo_rd_chan(fifo_rd_chan), .mem_rd_req(mem_rd_req), .mem_rd_chan(mem_rd_chan),
        .mem_rd_index(mem_rd_index), .mem_rd_high(mem_rd_high), .req_ready(req_ready),
        .rd_out(rd_out), .rd_out_ready(rd_out_ready), .fifo_read_pointer(rptr),
        .fifo_write_pointer(wptr));
////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    function automatic logic [31:0] xorshift(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        xorshift = x ^ (x << 5);
    endfunction : xorshift
    task automatic drain;
        for (int k = 0; k < 60 && q.size() != 0; k++) @(negedge sys_clk);
    endtask : drain
    task automatic ptrs(input string name);
        drain();
        chk(64'(rptr), 64'({rp[1], rp[0]}));
        chk(64'(wptr), 64'({wc[1], 1'b0, wc[0], 1'b0}));
        $display("test %s done", name);
    endtask : ptrs
    // Waits for an empty answer buffer, so up to two back-to-back requests are never refused.
    task automatic fetch(input logic f, input logic c, input logic [3:0] i, input logic h,
                         input int n, input logic [1:0] w);
        drain();
        for (int k = 0; k < 20 && !req_ready; k++) @(negedge sys_clk);
        for (int k = 0; k < n; k++) begin
            {fifo_rd_req, mem_rd_req, fifo_rd_chan, mem_rd_chan} = {f, !f, c, c};
            {mem_rd_index, mem_rd_high} = {i, h};
            if (f) begin
                {i, h} = {4'(rp[c][3:1]), rp[c][0]};
                rp[c]++;
            end
            q.push_back({1'b1, c, h, h ? mem[c][i[2:0]].high : mem[c][i[2:0]].low});
            @(negedge sys_clk);
        end
        {fifo_rd_req, mem_rd_req, go} = {2'b00, w};
        @(negedge sys_clk);
        go = 2'h0;
    endtask : fetch
////////////////////////////////////////////////////////////
    initial forever #12.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        rs = xorshift(rs);
        rd_out_ready = rs[0] | rs[1];
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            tally_and_finish();
        end
        for (int c = 0; c < 2; c++) begin
            if (flush[c]) wc[c] = 3'h0;
            else if (rx_wr_valid[c]) begin
                mem[c][wc[c]] = rx_wr_entry[c];
                wc[c]++;
            end
        end
        if (rd_out.valid && rd_out_ready)
            chk(64'(rd_out), q.size() ? 64'(q.pop_front()) : 64'h0);
    end
    initial begin
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        ptrs("reset");
        go = 2'b11;
        repeat (3) @(negedge sys_clk);
        go = 2'b01;
        @(negedge sys_clk);
        go = 2'h0;
        ptrs("writes");
        for (int k = 0; k < 4; k++) fetch(1'b1, k[0], 4'h0, 1'b0, 2, k[0] ? 2'b01 : 2'b10);
        ptrs("pairs");
        for (int k = 0; k < 6; k++) fetch(1'b0, 1'b1, 4'(k / 2), k[0], 1, 2'h0);
        ptrs("direct");
        flush = 2'b01;
        rp[0] = 4'h0;
        @(negedge sys_clk);
        flush = 2'h0;
        ptrs("flush");
        fetch(1'b0, 1'b0, 4'h0, 1'b0, 1, 2'b11);
        go = 2'b10;
        repeat (7) @(negedge sys_clk);
        go = 2'h0;
        fetch(1'b1, 1'b0, 4'h0, 1'b0, 2, 2'h0);
        fetch(1'b1, 1'b1, 4'h0, 1'b0, 2, 2'h0);
        ptrs("wrap");
        tally_and_finish();
    end
endmodule : test_sensor_rx_fifo_pointers
